// File: core/tmwm_pkg.sv
// constants and types shared by the timer waveform control block
package tmwm_pkg;

  // ------------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;
  localparam logic [7:0]  OFS_CTRL_A      = 8'hb0;
  localparam logic [7:0]  OFS_CTRL_B      = 8'hb1;
  localparam logic [7:0]  OFS_COUNT       = 8'hb2;
  localparam logic [7:0]  OFS_CMP_A       = 8'hb3;
  localparam logic [7:0]  OFS_CMP_B       = 8'hb4;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'hb6;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'hb7;
  localparam logic [7:0]  RST_VALUE       = 8'h00;
  localparam logic [7:0]  CTRL_A_WMASK    = 8'hf3;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_B_HIGH_POS = 3;
  localparam int unsigned FORCE_A_POS     = 7;
  localparam int unsigned FORCE_B_POS     = 6;
  localparam int unsigned EV_OVF          = 0;
  localparam int unsigned EV_MATCH_A      = 1;
  localparam int unsigned EV_MATCH_B      = 2;
  localparam int unsigned EV_W            = 3;

  // ------------------------------------------------------------------
  // counter landmarks and output action codes
  // ------------------------------------------------------------------
  localparam logic [7:0]  MAX_VALUE       = 8'hff;
  localparam logic [7:0]  BOTTOM_VALUE    = 8'h00;
  localparam logic [1:0]  ACT_OFF         = 2'b00;
  localparam logic [1:0]  ACT_TOGGLE      = 2'b01;
  localparam logic [1:0]  ACT_CLEAR       = 2'b10;
  localparam logic [1:0]  ACT_SET         = 2'b11;

  typedef enum logic [2:0] {
    TMWM_NORMAL    = 3'd0,
    TMWM_PHASE_FF  = 3'd1,
    TMWM_CTC       = 3'd2,
    TMWM_FAST_FF   = 3'd3,
    TMWM_RSVD4     = 3'd4,
    TMWM_PHASE_CMP = 3'd5,
    TMWM_RSVD6     = 3'd6,
    TMWM_FAST_CMP  = 3'd7
  } tmwm_mode_t;

  typedef enum logic {
    TMWM_UP   = 1'b0,
    TMWM_DOWN = 1'b1
  } tmwm_dir_t;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] rsvd;
    logic [1:0] mode_low;
  } tmwm_ctrl_a_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tmwm_bus_req_t;

endpackage

// File: core/tmwm_timer2_wave.sv
// 8-bit timer with two compare channels and waveform mode control
//
// The strobed register port was decided locally.
module tmwm_timer2_wave (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire tmwm_pkg::tmwm_bus_req_t bus_req,
  output logic [tmwm_pkg::DATA_W-1:0] rdata,
  output logic                        wave_out_a,
  output logic                        wave_out_b,
  output logic                        wave_sel_a,
  output logic                        wave_sel_b,
  output logic                        irq
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // plain compare action used for matches and forced matches in non-PWM modes
  function automatic logic act_level(input logic [1:0] act,
                                     input logic       cur);
    logic v;
    v = cur;
    case (act)
      tmwm_pkg::ACT_TOGGLE: v = ~cur;
      tmwm_pkg::ACT_CLEAR:  v = 1'b0;
      tmwm_pkg::ACT_SET:    v = 1'b1;
      default:              v = cur;
    endcase
    return v;
  endfunction

  // one waveform step for a channel
  function automatic logic wave_step(input logic       cur,
                                     input logic [1:0] act,
                                     input logic       fast,
                                     input logic       phase,
                                     input logic       match,
                                     input logic       at_bot,
                                     input logic       at_top,
                                     input logic       up,
                                     input logic       cmp_top,
                                     input logic       toggle_ok,
                                     input logic       force_m);
    logic v;
    v = cur;
    if (!fast && !phase) begin
      if (match || force_m) begin
        v = act_level(act, cur);
      end
    end else if (act == tmwm_pkg::ACT_TOGGLE) begin
      if (toggle_ok && match) begin
        v = ~cur;
      end
    end else if (act[1]) begin
      if (fast) begin
        if (at_bot) begin
          v = ~act[0];
        end
        if (match && !cmp_top) begin
          v = act[0];
        end
      end else if (cmp_top) begin
        if (at_top) begin
          v = ~act[0];
        end
      end else if (match) begin
        v = up ? act[0] : ~act[0];
      end
    end
    return v;
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  tmwm_pkg::tmwm_ctrl_a_t  ctrl_a;
  tmwm_pkg::tmwm_ctrl_a_t  next_ctrl_a;
  logic                    mode_high;
  logic                    next_mode_high;
  logic [7:0]              cnt;
  logic [7:0]              next_cnt;
  tmwm_pkg::tmwm_dir_t     dir;
  tmwm_pkg::tmwm_dir_t     next_dir;
  logic [7:0]              cmp_buf_a;
  logic [7:0]              next_cmp_buf_a;
  logic [7:0]              cmp_buf_b;
  logic [7:0]              next_cmp_buf_b;
  logic [7:0]              cmp_a;
  logic [7:0]              next_cmp_a;
  logic [7:0]              cmp_b;
  logic [7:0]              next_cmp_b;
  logic [tmwm_pkg::EV_W-1:0] status;
  logic [tmwm_pkg::EV_W-1:0] next_status;
  logic [tmwm_pkg::EV_W-1:0] mask;
  logic [tmwm_pkg::EV_W-1:0] next_mask;
  logic [7:0]              next_rdata;
  logic                    next_wave_a;
  logic                    next_wave_b;
  logic                    next_sel_a;
  logic                    next_sel_b;
  logic                    next_irq;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  tmwm_pkg::tmwm_mode_t    mode;
  logic                    is_fast;
  logic                    is_phase;
  logic                    is_pwm;
  logic                    top_is_cmp;
  logic                    immediate;
  logic [7:0]              top;
  logic                    at_top;
  logic                    at_bottom;
  logic                    match_a;
  logic                    match_b;
  logic                    cmp_top_a;
  logic                    cmp_top_b;
  logic                    cnt_wr;
  logic                    ctrl_b_wr;
  logic [tmwm_pkg::EV_W-1:0] events;

  // mode code joins the high bit of control B with the low bits
  always_comb begin
    mode       = tmwm_pkg::tmwm_mode_t'({mode_high, ctrl_a.mode_low});
    is_fast    = (mode == tmwm_pkg::TMWM_FAST_FF) ||
                 (mode == tmwm_pkg::TMWM_FAST_CMP);
    is_phase   = (mode == tmwm_pkg::TMWM_PHASE_FF) ||
                 (mode == tmwm_pkg::TMWM_PHASE_CMP);
    is_pwm     = is_fast || is_phase;
    top_is_cmp = (mode == tmwm_pkg::TMWM_CTC) ||
                 (mode == tmwm_pkg::TMWM_PHASE_CMP) ||
                 (mode == tmwm_pkg::TMWM_FAST_CMP);
    immediate  = !is_pwm;
    top        = top_is_cmp ? cmp_a : tmwm_pkg::MAX_VALUE;
    at_top     = (cnt == top);
    at_bottom  = (cnt == tmwm_pkg::BOTTOM_VALUE);
    match_a    = (cnt == cmp_a);
    match_b    = (cnt == cmp_b);
    cmp_top_a  = (cmp_a == top) && ctrl_a.act_a[1];
    cmp_top_b  = (cmp_b == top) && ctrl_a.act_b[1];
    cnt_wr     = bus_req.wr && (bus_req.addr == tmwm_pkg::OFS_COUNT);
    ctrl_b_wr  = bus_req.wr && (bus_req.addr == tmwm_pkg::OFS_CTRL_B);
  end

  // ------------------------------------------------------------------
  // counter, direction and compare buffering
  // ------------------------------------------------------------------
  // reserved codes 4 and 6 fall back to a free running up count
  always_comb begin
    next_cnt = cnt + 8'h01;
    next_dir = dir;
    if (is_phase) begin
      if (dir == tmwm_pkg::TMWM_UP) begin
        if (cnt >= top) begin
          next_dir = tmwm_pkg::TMWM_DOWN;
          next_cnt = at_bottom ? cnt : cnt - 8'h01;
        end
      end else if (at_bottom) begin
        next_dir = tmwm_pkg::TMWM_UP;
      end else begin
        next_cnt = cnt - 8'h01;
      end
    end else if (is_fast || mode == tmwm_pkg::TMWM_CTC) begin
      if (at_top) begin
        next_cnt = tmwm_pkg::BOTTOM_VALUE;
      end
    end else begin
      next_dir = tmwm_pkg::TMWM_UP;
    end
    if (cnt_wr) begin
      next_cnt = bus_req.wdata;
    end
    next_cmp_buf_a = cmp_buf_a;
    next_cmp_buf_b = cmp_buf_b;
    if (bus_req.wr && bus_req.addr == tmwm_pkg::OFS_CMP_A) begin
      next_cmp_buf_a = bus_req.wdata;
    end
    if (bus_req.wr && bus_req.addr == tmwm_pkg::OFS_CMP_B) begin
      next_cmp_buf_b = bus_req.wdata;
    end
    // fast loads as the count wraps to bottom, phase loads at top
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    if (immediate || at_top) begin
      next_cmp_a = next_cmp_buf_a;
      next_cmp_b = next_cmp_buf_b;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= tmwm_pkg::RST_VALUE;
      dir       <= tmwm_pkg::TMWM_UP;
      cmp_buf_a <= tmwm_pkg::RST_VALUE;
      cmp_buf_b <= tmwm_pkg::RST_VALUE;
      cmp_a     <= tmwm_pkg::RST_VALUE;
      cmp_b     <= tmwm_pkg::RST_VALUE;
    end else begin
      cnt       <= next_cnt;
      dir       <= next_dir;
      cmp_buf_a <= next_cmp_buf_a;
      cmp_buf_b <= next_cmp_buf_b;
      cmp_a     <= next_cmp_a;
      cmp_b     <= next_cmp_b;
    end
  end

  // ------------------------------------------------------------------
  // waveform outputs and pin hand-over
  // ------------------------------------------------------------------
  // the pin driver also needs its direction bit set outside this block
  always_comb begin
    next_wave_a = wave_step(wave_out_a, ctrl_a.act_a, is_fast, is_phase,
                            match_a, at_bottom, at_top,
                            dir == tmwm_pkg::TMWM_UP, cmp_top_a,
                            mode_high,
                            ctrl_b_wr && bus_req.wdata[tmwm_pkg::FORCE_A_POS]);
    next_wave_b = wave_step(wave_out_b, ctrl_a.act_b, is_fast, is_phase,
                            match_b, at_bottom, at_top,
                            dir == tmwm_pkg::TMWM_UP, cmp_top_b,
                            1'b0,
                            ctrl_b_wr && bus_req.wdata[tmwm_pkg::FORCE_B_POS]);
    next_sel_a  = (ctrl_a.act_a != tmwm_pkg::ACT_OFF) &&
                  !(is_pwm && ctrl_a.act_a == tmwm_pkg::ACT_TOGGLE &&
                    !mode_high);
    next_sel_b  = (ctrl_a.act_b != tmwm_pkg::ACT_OFF);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      wave_sel_a <= 1'b0;
      wave_sel_b <= 1'b0;
    end else begin
      wave_out_a <= next_wave_a;
      wave_out_b <= next_wave_b;
      wave_sel_a <= next_sel_a;
      wave_sel_b <= next_sel_b;
    end
  end

  // ------------------------------------------------------------------
  // registers, events and interrupt
  // ------------------------------------------------------------------
  // a flag set in the cycle of its clear survives, so no event is lost
  always_comb begin
    events = '0;
    if (is_phase) begin
      events[tmwm_pkg::EV_OVF] = at_bottom &&
                                 dir == tmwm_pkg::TMWM_DOWN;
    end else if (mode == tmwm_pkg::TMWM_FAST_CMP) begin
      events[tmwm_pkg::EV_OVF] = at_top;
    end else begin
      events[tmwm_pkg::EV_OVF] = (cnt == tmwm_pkg::MAX_VALUE);
    end
    events[tmwm_pkg::EV_MATCH_A] = match_a;
    events[tmwm_pkg::EV_MATCH_B] = match_b;
    next_ctrl_a    = ctrl_a;
    next_mode_high = mode_high;
    next_mask      = mask;
    next_status    = status;
    if (bus_req.wr) begin
      case (bus_req.addr)
        tmwm_pkg::OFS_CTRL_A: begin
          next_ctrl_a = bus_req.wdata & tmwm_pkg::CTRL_A_WMASK;
        end
        tmwm_pkg::OFS_CTRL_B: begin
          next_mode_high = bus_req.wdata[tmwm_pkg::CTRL_B_HIGH_POS];
        end
        tmwm_pkg::OFS_IRQ_MASK: begin
          next_mask = bus_req.wdata[tmwm_pkg::EV_W-1:0];
        end
        tmwm_pkg::OFS_IRQ_STATUS: begin
          next_status = status & ~bus_req.wdata[tmwm_pkg::EV_W-1:0];
        end
        default: begin
          next_mask = mask;
        end
      endcase
    end
    next_status = next_status | events;
    next_irq    = |(next_status & next_mask);
    next_rdata  = tmwm_pkg::RST_VALUE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        tmwm_pkg::OFS_CTRL_A:     next_rdata = ctrl_a;
        tmwm_pkg::OFS_CTRL_B:     next_rdata = {4'h0, mode_high, 3'h0};
        tmwm_pkg::OFS_COUNT:      next_rdata = cnt;
        tmwm_pkg::OFS_CMP_A:      next_rdata = cmp_buf_a;
        tmwm_pkg::OFS_CMP_B:      next_rdata = cmp_buf_b;
        tmwm_pkg::OFS_IRQ_MASK:   next_rdata = {5'h00, mask};
        tmwm_pkg::OFS_IRQ_STATUS: next_rdata = {5'h00, status};
        default:                  next_rdata = tmwm_pkg::RST_VALUE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_a    <= tmwm_pkg::RST_VALUE;
      mode_high <= 1'b0;
      mask      <= '0;
      status    <= '0;
      irq       <= 1'b0;
      rdata     <= tmwm_pkg::RST_VALUE;
    end else begin
      ctrl_a    <= next_ctrl_a;
      mode_high <= next_mode_high;
      mask      <= next_mask;
      status    <= next_status;
      irq       <= next_irq;
      rdata     <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_RSVD_READ_ZERO: assert property (
    bus_req.rd && bus_req.addr == tmwm_pkg::OFS_CTRL_A |=> rdata[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  AST_SEL_OFF: assert property (
    ctrl_a.act_b == tmwm_pkg::ACT_OFF |=> !wave_sel_b)
    else $error("channel b kept pin with zero action field");
  AST_NONPWM_TOGGLE: assert property (
    !is_pwm && ctrl_a.act_a == tmwm_pkg::ACT_TOGGLE && match_a
    |=> wave_out_a != $past(wave_out_a))
    else $error("non-pwm toggle on match missing");
  AST_NONPWM_SET: assert property (
    !is_pwm && ctrl_a.act_b == tmwm_pkg::ACT_SET && match_b |=> wave_out_b)
    else $error("non-pwm set on match missing");
  AST_PWM_TOGGLE_OFF: assert property (
    is_pwm && ctrl_a.act_a == tmwm_pkg::ACT_TOGGLE && !mode_high
    |=> !wave_sel_a)
    else $error("channel a code 01 took the pin with high bit clear");
  AST_FAST_BOTTOM_SET: assert property (
    is_fast && ctrl_a.act_a == tmwm_pkg::ACT_CLEAR && at_bottom &&
    !(match_a && !cmp_top_a) |=> wave_out_a)
    else $error("fast pwm non-inverting not set at bottom");
  AST_FAST_B_RSVD: assert property (
    is_pwm && ctrl_a.act_b == tmwm_pkg::ACT_TOGGLE
    |=> wave_out_b == $past(wave_out_b))
    else $error("reserved channel b code changed the output");
  AST_PHASE_UP_CLEAR: assert property (
    is_phase && ctrl_a.act_a == tmwm_pkg::ACT_CLEAR && match_a &&
    dir == tmwm_pkg::TMWM_UP && !cmp_top_a |=> !wave_out_a)
    else $error("phase pwm up-count match did not clear");
  AST_CTC_WRAP: assert property (
    mode == tmwm_pkg::TMWM_CTC && at_top && !cnt_wr
    |=> cnt == tmwm_pkg::BOTTOM_VALUE)
    else $error("clear-on-match mode did not restart at top");
  AST_NORMAL_OVF: assert property (
    mode == tmwm_pkg::TMWM_NORMAL && cnt == tmwm_pkg::MAX_VALUE && !cnt_wr
    |=> status[tmwm_pkg::EV_OVF] && cnt == tmwm_pkg::BOTTOM_VALUE)
    else $error("normal mode overflow flag or wrap missing");
  AST_IRQ_LEVEL: assert property (
    (status & mask) != '0 |-> irq)
    else $error("interrupt low with unmasked flag set");

  COV_FAST_CYCLE: cover property (
    is_fast && ctrl_a.act_a == tmwm_pkg::ACT_CLEAR && at_bottom ##[1:300]
    match_a);
  COV_PHASE_TURN: cover property (
    is_phase && dir == tmwm_pkg::TMWM_UP ##1 dir == tmwm_pkg::TMWM_DOWN);
  COV_IRQ: cover property ($rose(irq));

endmodule // tmwm_timer2_wave

// File: testbench/tmwm_timer2_wave_tb.sv
// self-checking bench for the timer waveform control block
module tmwm_timer2_wave_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------------
  logic                    mclk;
  logic                    resetn;
  tmwm_pkg::tmwm_bus_req_t bus_req;
  logic [7:0]              rdata;
  logic                    wave_out_a;
  logic                    wave_out_b;
  logic                    wave_sel_a;
  logic                    wave_sel_b;
  logic                    irq;
  int                      mismatches;
  int                      compares;
  int                      cycles;
  logic                    held;

  localparam logic [7:0] CA  = tmwm_pkg::OFS_CTRL_A;
  localparam logic [7:0] CB  = tmwm_pkg::OFS_CTRL_B;
  localparam logic [7:0] CNT = tmwm_pkg::OFS_COUNT;
  localparam logic [7:0] CMA = tmwm_pkg::OFS_CMP_A;
  localparam logic [7:0] CMB = tmwm_pkg::OFS_CMP_B;
  localparam logic [7:0] MSK = tmwm_pkg::OFS_IRQ_MASK;
  localparam logic [7:0] STS = tmwm_pkg::OFS_IRQ_STATUS;

  tmwm_timer2_wave i_dut (
    .mclk       (mclk),
    .resetn     (resetn),
    .bus_req    (bus_req),
    .rdata      (rdata),
    .wave_out_a (wave_out_a),
    .wave_out_b (wave_out_b),
    .wave_sel_a (wave_sel_a),
    .wave_sel_b (wave_sel_b),
    .irq        (irq)
  );

  // free running 125 MHz clock
  always #4 mclk = ~mclk;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs a few thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs are registered, so look 1 ns after the edge
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge mclk);
    bus_req.wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge mclk);
    bus_req.rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rdck(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] v;
    rdv(a, v);
    chk(v & m, e);
  endtask

  // sampled count must never pass the top value
  task automatic check_top(input logic [7:0] top);
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      idle(13);
      rdv(CNT, v);
      chk({7'h0, v <= top}, 8'h01);
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    rdck(CA, 8'hff, 8'h00);
    rdck(CMA, 8'hff, 8'h00);
    rdck(STS, 8'hff, 8'h06); // zero count meets both zero compares
    chk({6'h0, wave_sel_a, wave_sel_b}, 8'h00);
    wr(CA, 8'hff);
    rdck(CA, 8'hff, 8'hf3);
    wr(CB, 8'h3f);
    rdck(CB, 8'hff, 8'h08);
    idle(2);
    chk({6'h0, wave_sel_a, wave_sel_b}, 8'h03);
    wr(8'hb5, 8'h55);
    rdck(8'hb5, 8'hff, 8'h00);
    wr(CB, 8'h00);
    wr(CA, 8'h00);
    idle(2);
    chk({6'h0, wave_sel_a, wave_sel_b}, 8'h00);
  endtask

  // clear, set, then two toggles, one match per pass
  task automatic t_nonpwm();
    logic [1:0] code [4];
    logic       lvl  [4];
    code = '{2'b10, 2'b11, 2'b01, 2'b01};
    lvl  = '{1'b0, 1'b1, 1'b0, 1'b1};
    wr(CMA, 8'h40);
    wr(CMB, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(CA, {code[i], code[i], 4'h0});
      wr(CNT, 8'h38);
      idle(16);
      chk({6'h0, wave_sel_a, wave_sel_b}, 8'h03);
      chk({6'h0, wave_out_a, wave_out_b}, {6'h0, lvl[i], lvl[i]});
    end
    // force strobes act like a match, so the toggle code flips both
    wr(CB, 8'hc0);
    idle(2);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h00);
  endtask

  task automatic t_irq();
    wr(MSK, 8'h01);
    wr(STS, 8'h07);
    wr(CNT, 8'hf0);
    idle(20);
    chk({7'h0, irq}, 8'h01);
    rdck(STS, 8'h01, 8'h01);
    wr(MSK, 8'h00);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    wr(MSK, 8'h01);
    idle(2);
    chk({7'h0, irq}, 8'h01);
    wr(STS, 8'h01);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    wr(MSK, 8'h00);
  endtask

  // top from compare A keeps the count far below max
  task automatic t_ctc();
    wr(CMA, 8'h10);
    wr(CA, 8'h02);
    wr(CNT, 8'h00);
    wr(STS, 8'h07);
    check_top(8'h10);
    rdck(STS, 8'h01, 8'h00);
  endtask

  task automatic t_fast();
    int ones;
    wr(CA, 8'h00);
    wr(CMA, 8'h40);
    wr(CMB, 8'h30);
    wr(CA, 8'ha3);
    wr(CNT, 8'hf8);
    idle(16);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h03);
    wr(CMA, 8'h20);
    idle(36);
    chk({7'h0, wave_out_a}, 8'h01);
    idle(32);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h00);
    wr(CA, 8'hf3);
    wr(CMA, 8'hff);
    wr(CMB, 8'h10);
    wr(CNT, 8'hf8);
    idle(16);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h00);
    idle(16);
    chk({7'h0, wave_out_b}, 8'h01);
    wr(STS, 8'h07);
    ones = 0;
    for (int i = 0; i < 300; i++) begin
      idle(1);
      ones += int'(wave_out_a !== 1'b0);
    end
    chk(8'(ones), 8'h00);
    rdck(STS, 8'h01, 8'h01);
    wr(CA, 8'h53);
    idle(2);
    chk({6'h0, wave_sel_a, wave_sel_b}, 8'h01);
    held = wave_out_b;
    idle(300);
    chk({7'h0, wave_out_b}, {7'h0, held});
  endtask

  task automatic t_fast7();
    wr(CA, 8'h00);
    wr(CMA, 8'h80);
    wr(CA, 8'h43);
    wr(CB, 8'h08);
    rdck(CB, 8'hff, 8'h08);
    wr(CNT, 8'h10);
    idle(2);
    chk({7'h0, wave_sel_a}, 8'h01);
    held = wave_out_a;
    wr(STS, 8'h07);
    wr(CNT, 8'h78);
    idle(16);
    chk({7'h0, wave_out_a}, {7'h0, ~held});
    rdck(STS, 8'h01, 8'h01);
    check_top(8'h80);
  endtask

  // load zero so the count is known to rise
  task automatic t_phase1();
    wr(CB, 8'h00);
    wr(CA, 8'h00);
    wr(CMA, 8'h40);
    wr(CMB, 8'h40);
    wr(CA, 8'ha1);
    wr(CNT, 8'h00);
    idle(4);
    wr(STS, 8'h07);
    idle(74);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h00);
    idle(220);
    rdck(STS, 8'h01, 8'h00);
    idle(155);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h03);
    idle(70);
    rdck(STS, 8'h01, 8'h01);
  endtask

  task automatic t_phase5();
    wr(CA, 8'h00);
    wr(CMA, 8'h60);
    wr(CMB, 8'h60);
    wr(CA, 8'he9);
    wr(CB, 8'h08);
    wr(CNT, 8'h00);
    idle(200);
    chk({6'h0, wave_out_a, wave_out_b}, 8'h01);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    mclk       = 1'b0;
    resetn     = 1'b0;
    bus_req    = '0;
    mismatches = 0;
    compares   = 0;
    cycles     = 0;
    held       = 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_nonpwm();
    t_irq();
    t_ctc();
    t_fast();
    t_fast7();
    t_phase1();
    t_phase5();
    conclude();
  end

endmodule // tmwm_timer2_wave_tb
